// ---- logic/pod_cfg_top.sv ----
`timescale 1ns/1ns
module pod_cfg_top
  import pod_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic sen_b,
  input wire logic powerdown_pin,
  output logic [7:0] chan_sleep,
  output logic chan_deep_sleep,
  output logic chip_powerdown,
  output logic ref_enable,
  output logic clk_drv_oe_b,
  output logic [7:0] data_drv_oe_b,
  output logic [7:0] data_drv_power,
  output logic [7:0] data_force_zero,
  output pod_mode_t power_mode,
  output pod_lane_sel_t drive_sel,
  output pod_half_ma_t drive_half_ma,
  output pod_lane_sel_t term_sel,
  output pod_ohms_t term_ohms
);

  // Decoded write word from the serial port
  pod_wr_t wr;
  logic wr_vld;

  // Serial control port
  pod_spi_rx u_spi_rx (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .sclk(sclk),
    .sdata(sdata),
    .sen_b(sen_b),
    .wr(wr),
    .wr_vld(wr_vld)
  );

  logic soft_rst_ff;
  logic [7:0] light_ff;
  logic deep_ff;
  logic full_ff;
  logic [1:0] pin_act_ff;
  pod_lane_sel_t drive_ff;
  pod_lane_sel_t term_ff;
  logic term_en_ff;
  logic idle_sel_ff;

  // Address decode
  wire wr_rst = wr_vld & (wr.addr == POD_SOFTWARE_RESET_CTRL) & wr.data[POD_SOFT_RST_BIT];
  wire wr_pwr = wr_vld & (wr.addr == POD_POWER_MODE_CTRL);
  wire wr_drv = wr_vld & (wr.addr == POD_OUTPUT_DRIVE_STRENGTH);
  wire wr_term = wr_vld & (wr.addr == POD_OUTPUT_TERMINATION_CTRL);
  wire wr_idle = wr_vld & (wr.addr == POD_OUTPUT_IDLE_BEHAVIOUR);

  // Software reset bit: set by the write, cleared on the following edge
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      soft_rst_ff <= 1'b0;
    end else begin
      soft_rst_ff <= wr_rst;
    end
  end

  // Control registers; the held reset bit wins over any write in that cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      light_ff <= POD_LIGHT_RST;
      deep_ff <= 1'b0;
      full_ff <= 1'b0;
      pin_act_ff <= POD_PIN_ACT_RST;
    end else if (soft_rst_ff) begin
      light_ff <= POD_LIGHT_RST;
      deep_ff <= 1'b0;
      full_ff <= 1'b0;
      pin_act_ff <= POD_PIN_ACT_RST;
    end else if (wr_pwr) begin
      light_ff <= wr.data[POD_LIGHT_LSB +: 8];
      deep_ff <= wr.data[POD_DEEP_BIT];
      full_ff <= wr.data[POD_FULL_BIT];
      pin_act_ff <= wr.data[POD_PIN_ACT_LSB +: 2];
    end
  end

  // Drive current selections; the reset code is the 3.5 mA setting
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      drive_ff <= {POD_DRIVE_RST, POD_DRIVE_RST, POD_DRIVE_RST};
    end else if (soft_rst_ff) begin
      drive_ff <= {POD_DRIVE_RST, POD_DRIVE_RST, POD_DRIVE_RST};
    end else if (wr_drv) begin
      drive_ff.bclk <= wr.data[POD_BCLK_LSB +: 3];
      drive_ff.frame_clock_out <= wr.data[POD_FRAME_CLOCK_OUT_LSB +: 3];
      drive_ff.data <= wr.data[POD_DATA_LSB +: 3];
    end
  end

  // Termination codes and their common enable arrive together in one word
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      term_ff <= {POD_TERM_RST, POD_TERM_RST, POD_TERM_RST};
      term_en_ff <= 1'b0;
    end else if (soft_rst_ff) begin
      term_ff <= {POD_TERM_RST, POD_TERM_RST, POD_TERM_RST};
      term_en_ff <= 1'b0;
    end else if (wr_term) begin
      term_ff.bclk <= wr.data[POD_BCLK_LSB +: 3];
      term_ff.frame_clock_out <= wr.data[POD_FRAME_CLOCK_OUT_LSB +: 3];
      term_ff.data <= wr.data[POD_DATA_LSB +: 3];
      term_en_ff <= wr.data[POD_TERM_EN_BIT];
    end
  end

  // Idle behaviour of the data drivers while their channel sleeps
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      idle_sel_ff <= 1'b0;
    end else if (soft_rst_ff) begin
      idle_sel_ff <= 1'b0;
    end else if (wr_idle) begin
      idle_sel_ff <= wr.data[POD_IDLE_SEL_BIT];
    end
  end

  // Pin mapping; the pin is a level, so dropping it leaves the state at once
  wire pin_light = powerdown_pin & pin_act_ff[0];
  wire pin_deep = powerdown_pin & (pin_act_ff == POD_PIN_DEEP);
  wire pin_full = powerdown_pin & (pin_act_ff == POD_PIN_FULL);

  // Effective power states; full power-down overrides both sleeps
  wire eff_full = full_ff | pin_full;
  wire eff_deep = (deep_ff | pin_deep) & ~eff_full;
  wire [7:0] eff_light = (light_ff | {8{pin_light}}) & {8{~eff_full & ~eff_deep}};

  // Summary mode, reported for the most severe state present
  wire pod_mode_t nxt_mode = eff_full ? POD_OFF : (eff_deep ? POD_DEEP : ((|eff_light) ? POD_LIGHT : POD_RUN));

  // Lane sleep: a lane idles when its own channel sleeps or everything does
  wire [7:0] lane_idle = eff_light | {8{eff_deep}};

  // Next-state lane controls
  logic [7:0] nxt_oe_b;
  logic [7:0] nxt_power;
  logic [7:0] nxt_zero;

  // Per-lane data driver state
  genvar gi;
  generate
    for (gi = 0; gi < POD_CHANNELS; gi++) begin : g_lane
      // Hi-Z when off, or idling with idle select clear
      assign nxt_oe_b[gi] = eff_full | (lane_idle[gi] & ~idle_sel_ff);
      assign nxt_power[gi] = ~nxt_oe_b[gi];
      assign nxt_zero[gi] = ~eff_full & lane_idle[gi] & idle_sel_ff;
    end
  endgenerate

  // Drive current lookup in half-milliamp units
  function automatic logic [3:0] half_ma(input logic [2:0] code);
    logic [3:0] v;
    v = 4'h7;
    unique case (code)
      3'h0: v = 4'h7;
      3'h1: v = 4'h5;
      3'h2: v = 4'h3;
      3'h3: v = 4'h1;
      3'h4: v = 4'hF;
      3'h5: v = 4'hD;
      3'h6: v = 4'hB;
      3'h7: v = 4'h9;
    endcase
    return v;
  endfunction : half_ma

  // Termination lookup in ohms
  function automatic logic [8:0] ohms(input logic [2:0] code);
    logic [8:0] v;
    v = 9'h000;
    unique case (code)
      3'h0: v = 9'h000;
      3'h1: v = 9'h118;
      3'h2: v = 9'h0A5;
      3'h3: v = 9'h064;
      3'h4: v = 9'h07D;
      3'h5: v = 9'h052;
      3'h6: v = 9'h043;
      3'h7: v = 9'h038;
    endcase
    return v;
  endfunction : ohms

  // Termination only takes effect with the enable bit set
  wire pod_lane_sel_t nxt_term = term_en_ff ? term_ff : {POD_TERM_OFF, POD_TERM_OFF, POD_TERM_OFF};

  wire pod_half_ma_t nxt_half_ma = {half_ma(drive_ff.data), half_ma(drive_ff.frame_clock_out), half_ma(drive_ff.bclk)};
  wire pod_ohms_t nxt_ohms = {ohms(nxt_term.data), ohms(nxt_term.frame_clock_out), ohms(nxt_term.bclk)};

  logic [7:0] chan_sleep_ff;
  logic deep_out_ff;
  logic full_out_ff;
  logic ref_en_ff;
  logic clk_oe_b_ff;
  logic [7:0] oe_b_ff;
  logic [7:0] power_ff;
  logic [7:0] zero_ff;
  pod_mode_t mode_ff;
  pod_lane_sel_t drive_out_ff;
  pod_half_ma_t half_ma_ff;
  pod_lane_sel_t term_out_ff;
  pod_ohms_t ohms_ff;

  // Power state outputs; reset shows the fully powered, running state
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      chan_sleep_ff <= 8'h00;
      deep_out_ff <= 1'b0;
      full_out_ff <= 1'b0;
      mode_ff <= POD_RUN;
    end else begin
      chan_sleep_ff <= eff_light;
      deep_out_ff <= eff_deep;
      full_out_ff <= eff_full;
      mode_ff <= nxt_mode;
    end
  end

  // Reference enable gets its own flop so the pin carries no gate glitch
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_en_ff <= 1'b1;
    end else begin
      ref_en_ff <= ~eff_full;
    end
  end

  // Clock lane drivers float only in full power-down, never for idle select
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_oe_b_ff <= 1'b0;
    end else begin
      clk_oe_b_ff <= eff_full;
    end
  end

  // Data lane drivers; power and enable share one decode so they never disagree
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      oe_b_ff <= 8'h00;
      power_ff <= 8'hFF;
      zero_ff <= 8'h00;
    end else begin
      oe_b_ff <= nxt_oe_b;
      power_ff <= nxt_power;
      zero_ff <= nxt_zero;
    end
  end

  // Drive strength and termination as presented to the output buffers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      drive_out_ff <= '0;
      half_ma_ff <= {4'h7, 4'h7, 4'h7};
      term_out_ff <= '0;
      ohms_ff <= '0;
    end else begin
      drive_out_ff <= drive_ff;
      half_ma_ff <= nxt_half_ma;
      term_out_ff <= nxt_term;
      ohms_ff <= nxt_ohms;
    end
  end

  assign chan_sleep = chan_sleep_ff;
  assign chan_deep_sleep = deep_out_ff;
  assign chip_powerdown = full_out_ff;
  // Reference stays up in both sleeps; only full power-down drops it
  assign ref_enable = ref_en_ff;
  assign clk_drv_oe_b = clk_oe_b_ff;
  assign data_drv_oe_b = oe_b_ff;
  assign data_drv_power = power_ff;
  assign data_force_zero = zero_ff;
  assign power_mode = mode_ff;
  assign drive_sel = drive_out_ff;
  assign drive_half_ma = half_ma_ff;
  assign term_sel = term_out_ff;
  assign term_ohms = ohms_ff;

endmodule : pod_cfg_top

// ---- logic/pod_pkg.sv ----
package pod_pkg;

  // Serial word layout: address byte then sixteen data bits, most significant first
  localparam int unsigned POD_ADDR_W = 8;
  localparam int unsigned POD_DATA_W = 16;
  localparam int unsigned POD_WORD_W = POD_ADDR_W + POD_DATA_W;
  localparam logic [4:0] POD_WORD_LAST = 5'h17;

  // Register offsets
  localparam logic [7:0] POD_SOFTWARE_RESET_CTRL = 8'h00;
  localparam logic [7:0] POD_POWER_MODE_CTRL = 8'h0F;
  localparam logic [7:0] POD_OUTPUT_DRIVE_STRENGTH = 8'h11;
  localparam logic [7:0] POD_OUTPUT_TERMINATION_CTRL = 8'h12;
  localparam logic [7:0] POD_OUTPUT_IDLE_BEHAVIOUR = 8'h52;

  // Field positions
  localparam int unsigned POD_SOFT_RST_BIT = 0;
  localparam int unsigned POD_LIGHT_LSB = 0;
  localparam int unsigned POD_DEEP_BIT = 8;
  localparam int unsigned POD_FULL_BIT = 9;
  localparam int unsigned POD_PIN_ACT_LSB = 10;
  localparam int unsigned POD_BCLK_LSB = 0;
  localparam int unsigned POD_FRAME_CLOCK_OUT_LSB = 4;
  localparam int unsigned POD_DATA_LSB = 8;
  localparam int unsigned POD_TERM_EN_BIT = 14;
  localparam int unsigned POD_IDLE_SEL_BIT = 0;

  localparam int unsigned POD_CHANNELS = 8;

  // Pin action encodings
  localparam logic [1:0] POD_PIN_FULL = 2'h0;
  localparam logic [1:0] POD_PIN_DEEP = 2'h2;

  // Reset values
  localparam logic [7:0] POD_LIGHT_RST = 8'h00;
  localparam logic [1:0] POD_PIN_ACT_RST = 2'h0;
  localparam logic [2:0] POD_DRIVE_RST = 3'h0;
  localparam logic [2:0] POD_TERM_RST = 3'h0;
  localparam logic [2:0] POD_TERM_OFF = 3'h0;

  // One three-bit selection per driver group
  typedef struct packed {
    logic [2:0] data;
    logic [2:0] frame_clock_out;
    logic [2:0] bclk;
  } pod_lane_sel_t;

  // Drive current in half-milliamp units, per group
  typedef struct packed {
    logic [3:0] data;
    logic [3:0] frame_clock_out;
    logic [3:0] bclk;
  } pod_half_ma_t;

  // Termination in ohms per group, zero meaning off
  typedef struct packed {
    logic [8:0] data;
    logic [8:0] frame_clock_out;
    logic [8:0] bclk;
  } pod_ohms_t;

  // Decoded register write from the serial port
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] data;
  } pod_wr_t;

  typedef enum logic [1:0] {
    POD_RUN,
    POD_LIGHT,
    POD_DEEP,
    POD_OFF
  } pod_mode_t;

endpackage : pod_pkg

// ---- logic/pod_spi_rx.sv ----
`timescale 1ns/1ns
// Serial control port receiver: collects one address plus data word while the
// enable is low and strobes it out when the last bit arrives.
module pod_spi_rx
  import pod_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic sen_b,
  output pod_wr_t wr,
  output logic wr_vld
);

  logic sclk_ff;
  logic [4:0] cnt_ff;
  logic [4:0] nxt_cnt;
  logic [23:0] shift_ff;
  logic [23:0] nxt_shift;
  logic wr_vld_ff;
  pod_wr_t wr_ff;
  wire sclk_rise;
  wire last_bit;

  // Pins are synchronous, so a registered copy is enough for edge detection
  assign sclk_rise = sclk & ~sclk_ff & ~sen_b;
  assign last_bit = sclk_rise & (cnt_ff == POD_WORD_LAST);
  assign nxt_shift = sclk_rise ? {shift_ff[22:0], sdata} : shift_ff;
  // A frame cut short by the enable rising is dropped, never half-written
  assign nxt_cnt = sen_b ? 5'h00 : (last_bit ? 5'h00 : (sclk_rise ? cnt_ff + 5'h01 : cnt_ff));

  // Shifter and bit counter
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_ff <= 1'b0;
      cnt_ff <= 5'h00;
      shift_ff <= 24'h000000;
      wr_vld_ff <= 1'b0;
      wr_ff <= '0;
    end else begin
      sclk_ff <= sclk;
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
      wr_vld_ff <= last_bit;
      if (last_bit) begin
        wr_ff <= {shift_ff[22:0], sdata};
      end
    end
  end

  assign wr = wr_ff;
  assign wr_vld = wr_vld_ff;

endmodule : pod_spi_rx

// ---- tb/pod_rx_model.sv ----
`timescale 1ns/1ns
// Far-end receiver: it can only hold lock while the clock lanes are driven
module pod_rx_model
  import pod_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_drv_oe_b,
  output logic sync_ok_ff
);
  // Lock drops a cycle after the clock drivers float, as a real receiver would
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_ok_ff <= 1'b0;
    end else begin
      sync_ok_ff <= !clk_drv_oe_b;
    end
  end
endmodule : pod_rx_model

// ---- tb/pod_cfg_checker.sv ----
`timescale 1ns/1ns
module pod_cfg_checker
  import pod_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic powerdown_pin,
  input wire logic [7:0] chan_sleep,
  input wire logic chan_deep_sleep,
  input wire logic chip_powerdown,
  input wire logic ref_enable,
  input wire logic clk_drv_oe_b,
  input wire logic [7:0] data_drv_oe_b,
  input wire logic [7:0] data_drv_power,
  input wire logic [7:0] data_force_zero,
  input wire pod_mode_t power_mode,
  input wire pod_lane_sel_t drive_sel,
  input wire pod_half_ma_t drive_half_ma,
  input wire pod_lane_sel_t term_sel,
  input wire pod_ohms_t term_ohms
);
  localparam logic [8:0] OHM [8] = '{9'h000, 9'h118, 9'h0A5, 9'h064, 9'h07D, 9'h052, 9'h043, 9'h038};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Half-milliamp value for a drive code; upper half of codes is the strong range
  function automatic logic [3:0] hm(input logic [2:0] c);
    return c[2] ? 4'(15 - 2 * c[1:0]) : 4'(7 - 2 * c[1:0]);
  endfunction : hm
  sequence s_pin_up;
    $rose(powerdown_pin);
  endsequence
  sequence s_pin_light;
    s_pin_up ##1 (power_mode == POD_LIGHT);
  endsequence
  a_ref_tracks_off: assert property (ref_enable == !chip_powerdown) else $error("reference on in power-down");
  a_clk_float_off: assert property (clk_drv_oe_b == chip_powerdown) else $error("clock driver state wrong");
  a_mode_off_flag: assert property ((power_mode == POD_OFF) == chip_powerdown) else $error("off mode mismatch");
  a_deep_keeps_clk: assert property (chan_deep_sleep |-> !clk_drv_oe_b && power_mode == POD_DEEP)
    else $error("deep sleep lost clocks");
  a_zero_needs_drive: assert property (
    (data_force_zero & data_drv_oe_b) == 8'h00 && data_drv_power == ~data_drv_oe_b)
    else $error("lane driver state inconsistent");
  a_drive_code_map: assert property (drive_half_ma == {hm(drive_sel.data), hm(drive_sel.frame_clock_out), hm(drive_sel.bclk)})
    else $error("drive current decode wrong");
  a_term_code_map: assert property (term_ohms == {OHM[term_sel.data], OHM[term_sel.frame_clock_out], OHM[term_sel.bclk]})
    else $error("termination decode wrong");
  a_pin_sleeps: assert property (s_pin_up |=> power_mode != POD_RUN) else $error("pin did not sleep");
  a_pin_light_all: assert property (s_pin_light |-> chan_sleep == 8'hFF) else $error("pin light sleep partial");
endmodule : pod_cfg_checker
bind pod_cfg_top pod_cfg_checker chk_u (.ref_clk, .rst_b, .powerdown_pin, .chan_sleep, .chan_deep_sleep,
  .chip_powerdown, .ref_enable, .clk_drv_oe_b, .data_drv_oe_b, .data_drv_power, .data_force_zero, .power_mode,
  .drive_sel, .drive_half_ma, .term_sel, .term_ohms);

// ---- tb/pod_cfg_top_test.sv ----
`timescale 1ns/1ns
module pod_cfg_top_test;
  import pod_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic sclk = 1'b0;
  logic sdata = 1'b0;
  logic sen_b = 1'b1;
  logic powerdown_pin = 1'b0;
  logic [7:0] chan_sleep, data_drv_oe_b, data_drv_power, data_force_zero;
  logic chan_deep_sleep, chip_powerdown, ref_enable, clk_drv_oe_b, sync_ok_ff;
  pod_mode_t power_mode;
  pod_lane_sel_t drive_sel, term_sel;
  pod_half_ma_t drive_half_ma;
  pod_ohms_t term_ohms;
  int failures = 0;
  int n_checks = 0;
  logic [3:0] ma_tab [8] = '{4'h7, 4'h5, 4'h3, 4'h1, 4'hF, 4'hD, 4'hB, 4'h9};
  logic [8:0] ohm_tab [8] = '{9'h000, 9'h118, 9'h0A5, 9'h064, 9'h07D, 9'h052, 9'h043, 9'h038};
  pod_mode_t pin_exp [4] = '{POD_OFF, POD_LIGHT, POD_DEEP, POD_LIGHT};
  always #5 ref_clk = ~ref_clk;
  pod_cfg_top dut_u (.ref_clk, .rst_b, .sclk, .sdata, .sen_b, .powerdown_pin, .chan_sleep, .chan_deep_sleep,
    .chip_powerdown, .ref_enable, .clk_drv_oe_b, .data_drv_oe_b, .data_drv_power, .data_force_zero, .power_mode,
    .drive_sel, .drive_half_ma, .term_sel, .term_ohms);
  pod_rx_model rx_u (.ref_clk, .rst_b, .clk_drv_oe_b, .sync_ok_ff);
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  // Serial word, MSB first; fewer than 24 bits makes an aborted frame
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input int n = 24);
    logic [23:0] w;
    w = {a, d};
    @(negedge ref_clk) sen_b = 1'b0;
    for (int i = 23; i > 23 - n; i--) begin
      @(negedge ref_clk) begin sclk = 1'b0; sdata = w[i]; end
      @(negedge ref_clk) sclk = 1'b1;
    end
    @(negedge ref_clk) begin sclk = 1'b0; sen_b = 1'b1; end
    repeat (4) @(negedge ref_clk);
  endtask : wr
  task automatic pin(input logic v);
    powerdown_pin = v;
    repeat (3) @(negedge ref_clk);
  endtask : pin
  task automatic conclude;
    if (failures == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude
  // Watchdog far above the roughly 30 frames of about 55 cycles each
  initial begin
    #500000;
    failures++;
    conclude();
  end
  // Directed sequence: defaults, writes, sleep modes, pin mapping, both resets
  initial begin
    repeat (2) @(negedge ref_clk);
    rst_b = 1'b1;
    chk("mode", POD_RUN, power_mode);
    chk("drive", 32'h777, drive_half_ma);
    chk("drive_sel", 32'h0, drive_sel);
    for (int c = 0; c < 8; c++) begin
      wr(8'h11, {5'h00, 3'(c + 2), 1'b0, 3'(c + 1), 1'b0, 3'(c)});
      chk("drive", {ma_tab[(c + 2) % 8], ma_tab[(c + 1) % 8], ma_tab[c]}, drive_half_ma);
    end
    chk("drive_sel", {3'h1, 3'h0, 3'h7}, drive_sel);
    wr(8'h11, 16'h0000, 12);
    wr(8'h13, 16'h0000);
    chk("drive", {ma_tab[1], ma_tab[0], ma_tab[7]}, drive_half_ma);
    wr(8'h12, 16'h0777);
    chk("term", 32'h0, term_ohms);
    chk("term_sel", 32'h0, term_sel);
    for (int c = 0; c < 8; c++) begin
      wr(8'h12, 16'h4000 | {5'h00, 3'(c + 2), 1'b0, 3'(c + 1), 1'b0, 3'(c)});
      chk("term", {ohm_tab[(c + 2) % 8], ohm_tab[(c + 1) % 8], ohm_tab[c]}, term_ohms);
    end
    chk("term_sel", {3'h1, 3'h0, 3'h7}, term_sel);
    wr(8'h0F, 16'h0005);
    chk("sleep", 32'h05, chan_sleep);
    chk("lane_oe", 32'h05, data_drv_oe_b);
    chk("lane_power", 32'hFA, data_drv_power);
    chk("clk_oe", 32'h0, clk_drv_oe_b);
    wr(8'h52, 16'h0001);
    chk("lane_oe", 32'h00, data_drv_oe_b);
    chk("lane_power", 32'hFF, data_drv_power);
    chk("zero", 32'h05, data_force_zero);
    wr(8'h0F, 16'h0100);
    chk("deep", 32'h5, {chan_deep_sleep, clk_drv_oe_b, sync_ok_ff});
    chk("zero", 32'hFF, data_force_zero);
    wr(8'h52, 16'h0000);
    chk("lane_oe", 32'hFF, data_drv_oe_b);
    chk("lane_power", 32'h00, data_drv_power);
    chk("clk_oe", 32'h0, clk_drv_oe_b);
    wr(8'h0F, 16'h0200);
    chk("full", 32'hA, {chip_powerdown, ref_enable, clk_drv_oe_b, sync_ok_ff});
    chk("lane_oe", 32'hFF, data_drv_oe_b);
    for (int p = 0; p < 4; p++) begin
      wr(8'h0F, 16'(p << 10));
      pin(1'b1);
      chk("pin_mode", pin_exp[p], power_mode);
      if (p[0]) chk("pin_sleep", 32'hFF, chan_sleep);
      pin(1'b0);
      chk("pin_mode", POD_RUN, power_mode);
    end
    wr(8'h00, 16'h0000);
    chk("drive", {ma_tab[1], ma_tab[0], ma_tab[7]}, drive_half_ma);
    wr(8'h00, 16'h0001);
    chk("drive", 32'h777, drive_half_ma);
    chk("term", 32'h0, term_ohms);
    pin(1'b1);
    chk("pin_mode", POD_OFF, power_mode);
    pin(1'b0);
    wr(8'h11, 16'h0444);
    chk("drive", 32'hFFF, drive_half_ma);
    rst_b = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_b = 1'b1;
    chk("drive", 32'h777, drive_half_ma);
    chk("mode", POD_RUN, power_mode);
    conclude();
  end
endmodule : pod_cfg_top_test
